// >>> inc/dio_port_params.svh
// Register map, mode codes, reset values and field widths of the DIO port
`ifndef DIO_PORT_PARAMS_SVH
`define DIO_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define DIO_IDX_MODE1   10'h003
`define DIO_IDX_LINES_A 10'h004
`define DIO_IDX_LINES_B 10'h005
`define DIO_IDX_LINES_C 10'h006
`define DIO_IDX_MODE2   10'h007

// Word alignment of the register bus
`define DIO_ADDR_LSB    2
`define DIO_ALIGN_ZERO  2'h0

// Mode field codes
`define DIO_MODE_PRESET 2'h1
`define DIO_MODE_DIR    2'h2
`define DIO_MODE_NORMAL 2'h3

// Reset values
`define DIO_MODE_RST    2'h3
`define DIO_LINE_RST    8'h00

// Field and bus widths
`define DIO_MODE_W      2
`define DIO_DATA_W      32
`define DIO_BANKS       3

`endif

// >>> inc/dio_port_pkg.sv
// Shared types of the DIO port
package dio_port_pkg;

  // Two-bit access mode of a data register group
  typedef logic [1:0] mode_t;

  // APB data word
  typedef logic [31:0] word_t;

endpackage : dio_port_pkg

// >>> inc/dio_bank_if.sv
// Link between the register front end and one byte-wide line bank
`timescale 1ns/100ps
interface dio_bank_if #(
  parameter int W = 8
);
  logic                 wr_en;      // One-cycle write strobe
  logic [W-1:0]         wdata;      // Written byte
  dio_port_pkg::mode_t  mode;       // Governing access mode
  logic [W-1:0]         pins_sync;  // Synchronised pin levels
  logic [W-1:0]         level;      // Output level latch
  logic [W-1:0]         dir;        // Direction, 1 = output
  logic [W-1:0]         rdata;      // Mode dependent read value

  // Front end side
  modport ctrl (output wr_en, wdata, mode, pins_sync, input level, dir, rdata);
  // Bank side
  modport bank (input wr_en, wdata, mode, pins_sync, output level, dir, rdata);
endinterface : dio_bank_if

// >>> core/dio_in_sync.sv
// Two-flop synchroniser for the input pin levels
`timescale 1ns/100ps
module dio_in_sync #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;  // First stage, read only by second stage

  // Both stages clear on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : dio_in_sync

// >>> core/dio_line_bank.sv
// One byte-wide bank of lines: level latch, direction and read mux
`timescale 1ns/100ps
`include "dio_port_params.svh"
module dio_line_bank (
  input wire logic clk,
  input wire logic rst,
  dio_bank_if.bank bif
);

  // Level latch shared by preset and normal writes
  always_ff @(posedge clk) begin
    if (rst) begin
      bif.level <= `DIO_LINE_RST;
    end else if (bif.wr_en && bif.mode == `DIO_MODE_PRESET) begin
      bif.level <= bif.wdata;
    end else if (bif.wr_en && bif.mode == `DIO_MODE_NORMAL) begin
      // Input bits keep their old latch value
      bif.level <= (bif.wdata & bif.dir) | (bif.level & ~bif.dir);
    end
  end

  // Direction bits, 1 = drive
  always_ff @(posedge clk) begin
    if (rst) begin
      bif.dir <= `DIO_LINE_RST;
    end else if (bif.wr_en && bif.mode == `DIO_MODE_DIR) begin
      bif.dir <= bif.wdata;
    end
  end

  // Read value per mode; unused code reads zero
  always_comb begin
    unique case (bif.mode)
      `DIO_MODE_PRESET: bif.rdata = bif.level;
      `DIO_MODE_DIR:    bif.rdata = bif.dir;
      `DIO_MODE_NORMAL: bif.rdata = (bif.pins_sync & ~bif.dir) | (bif.level & bif.dir);
      default:          bif.rdata = `DIO_LINE_RST;
    endcase
  end

endmodule : dio_line_bank

// >>> core/dio_port_top.sv
// APB register front end of the mode switched 24-line DIO port
`timescale 1ns/100ps
`include "dio_port_params.svh"
module dio_port_top #(
  parameter int ADDR_W = 12,  // APB address width
  parameter int LINE_W = 8    // Lines per data register
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output dio_port_pkg::word_t              prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [`DIO_BANKS*LINE_W-1:0] pin_in,
  output logic      [`DIO_BANKS*LINE_W-1:0] pin_out,
  output logic      [`DIO_BANKS*LINE_W-1:0] pin_oe
);

  localparam int IDX_W = ADDR_W - `DIO_ADDR_LSB;  // Register index width
  localparam int NL    = `DIO_BANKS * LINE_W;     // Total line count

  // Register index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:`DIO_ADDR_LSB];
  endfunction : reg_index

  // Byte address is word aligned
  function automatic logic is_aligned(input logic [ADDR_W-1:0] a);
    is_aligned = (a[`DIO_ADDR_LSB-1:0] == `DIO_ALIGN_ZERO);
  endfunction : is_aligned

  // Address selects line bank number b
  function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input int b);
    bank_hit = is_aligned(a) && (reg_index(a) == IDX_W'(`DIO_IDX_LINES_A + b));
  endfunction : bank_hit

  // Address selects the given register index
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    idx_hit = is_aligned(a) && (reg_index(a) == IDX_W'(idx));
  endfunction : idx_hit

  // APB phases
  logic setup_ph;    // Setup cycle
  logic access_ph;   // Access cycle, completes now
  logic wr_take;     // Write of byte lane 0 takes effect
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_take   = access_ph && pwrite && pstrb[0];

  // Zero wait state slave
  assign pready = 1'b1;

  // Mode registers
  dio_port_pkg::mode_t mode1_r;   // first_port_mode_field
  dio_port_pkg::mode_t mode2_r;   // second_port_mode_field

  // Synchronised pin levels
  logic [NL-1:0] pins_sync;

  // Per-bank read values
  logic [LINE_W-1:0] bank_rd [`DIO_BANKS];

  // Read multiplexer output and decode error
  dio_port_pkg::word_t rd_nxt;
  logic                err_nxt;

  // Mode register of the first port; upper bits dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      mode1_r <= `DIO_MODE_RST;
    end else if (wr_take && idx_hit(paddr, `DIO_IDX_MODE1)) begin
      mode1_r <= pwdata[`DIO_MODE_W-1:0];
    end
  end

  // Mode register that governs the three line registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode2_r <= `DIO_MODE_RST;
    end else if (wr_take && idx_hit(paddr, `DIO_IDX_MODE2)) begin
      mode2_r <= pwdata[`DIO_MODE_W-1:0];
    end
  end

  // Input synchroniser for all lines
  dio_in_sync #(
    .W (NL)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pins_sync)
  );

  // Three line banks, each governed by the second mode register
  for (genvar i = 0; i < `DIO_BANKS; i++) begin : g_bank
    dio_bank_if #(.W(LINE_W)) bif ();
    // Strobe and data towards the bank
    assign bif.wr_en     = wr_take && bank_hit(paddr, i);
    assign bif.wdata     = pwdata[LINE_W-1:0];
    assign bif.mode      = mode2_r;
    assign bif.pins_sync = pins_sync[i*LINE_W +: LINE_W];
    // Pins and read value back from the bank
    assign pin_out[i*LINE_W +: LINE_W] = bif.level;
    assign pin_oe[i*LINE_W +: LINE_W]  = bif.dir;
    assign bank_rd[i] = bif.rdata;
    dio_line_bank u_bank (
      .clk (clk),
      .rst (rst),
      .bif (bif.bank)
    );
  end

  // Read value and decode error for the current address
  always_comb begin
    rd_nxt  = '0;
    err_nxt = 1'b0;
    if (idx_hit(paddr, `DIO_IDX_MODE1)) begin
      // Upper bits read zero
      rd_nxt = `DIO_DATA_W'(mode1_r);
    end else if (idx_hit(paddr, `DIO_IDX_MODE2)) begin
      rd_nxt = `DIO_DATA_W'(mode2_r);
    end else if (bank_hit(paddr, 0)) begin
      rd_nxt = `DIO_DATA_W'(bank_rd[0]);
    end else if (bank_hit(paddr, 1)) begin
      rd_nxt = `DIO_DATA_W'(bank_rd[1]);
    end else if (bank_hit(paddr, 2)) begin
      rd_nxt = `DIO_DATA_W'(bank_rd[2]);
    end else begin
      // Unmapped or misaligned address
      err_nxt = 1'b1;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup_ph) begin
      prdata <= pwrite ? '0 : rd_nxt;
    end
  end

  // Error flag captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= err_nxt;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Access phase helpers
  logic acc_rd;
  logic acc_wr;
  assign acc_rd = access_ph && !pwrite;
  assign acc_wr = wr_take;

  // Modes normal and lines cleared after reset
  a_reset_values: assert property (
    $past(rst) |-> (mode1_r == `DIO_MODE_RST) && (mode2_r == `DIO_MODE_RST)
                   && (pin_out == '0) && (pin_oe == '0))
    else $error("mode or lines not at reset value");

  // Mode register reads back its two bits only
  a_mode_readback: assert property (
    acc_wr && idx_hit(paddr, `DIO_IDX_MODE2) ##2 psel && !penable && !pwrite
      && idx_hit(paddr, `DIO_IDX_MODE2) ##1 penable
      |-> prdata == `DIO_DATA_W'($past(pwdata[`DIO_MODE_W-1:0], 3)))
    else $error("mode readback wrong");

  // First mode register leaves the line banks alone
  a_mode1_isolated: assert property (
    acc_wr && idx_hit(paddr, `DIO_IDX_MODE1)
      |=> $stable(pin_out) && $stable(pin_oe) && $stable(mode2_r))
    else $error("first mode write disturbed line banks");

  // Preset write sets the full level byte next cycle
  a_preset_write: assert property (
    acc_wr && bank_hit(paddr, 0) && mode2_r == `DIO_MODE_PRESET
      |=> pin_out[LINE_W-1:0] == $past(pwdata[LINE_W-1:0])
          && $stable(pin_oe))
    else $error("preset write did not set levels");

  // Direction write sets enables, levels untouched
  a_dir_write: assert property (
    acc_wr && bank_hit(paddr, 1) && mode2_r == `DIO_MODE_DIR
      |=> pin_oe[2*LINE_W-1:LINE_W] == $past(pwdata[LINE_W-1:0])
          && $stable(pin_out))
    else $error("direction write wrong");

  // Normal write only changes output lines
  a_normal_write: assert property (
    acc_wr && bank_hit(paddr, 0) && mode2_r == `DIO_MODE_NORMAL
      |=> pin_out[LINE_W-1:0] ==
          (($past(pwdata[LINE_W-1:0]) & $past(pin_oe[LINE_W-1:0]))
           | ($past(pin_out[LINE_W-1:0]) & ~$past(pin_oe[LINE_W-1:0]))))
    else $error("normal write touched input lines");

  // Preset read returns the level latch
  a_preset_read: assert property (
    acc_rd && bank_hit(paddr, 2) && mode2_r == `DIO_MODE_PRESET
      |-> prdata == `DIO_DATA_W'(pin_out[3*LINE_W-1:2*LINE_W]))
    else $error("preset read wrong");

  // Direction read returns the enables
  a_dir_read: assert property (
    acc_rd && bank_hit(paddr, 0) && mode2_r == `DIO_MODE_DIR
      |-> prdata == `DIO_DATA_W'(pin_oe[LINE_W-1:0]))
    else $error("direction read wrong");

  // Normal read merges pins and latch as seen at setup
  a_normal_read: assert property (
    acc_rd && bank_hit(paddr, 0) && mode2_r == `DIO_MODE_NORMAL
      |-> prdata == `DIO_DATA_W'(($past(pins_sync[LINE_W-1:0]) & ~pin_oe[LINE_W-1:0])
                               | (pin_out[LINE_W-1:0] & pin_oe[LINE_W-1:0])))
    else $error("normal read wrong");

  // Synchronised level lags the pin by two cycles
  a_sync_delay: assert property (
    !$past(rst, 2) && !$past(rst) |-> pins_sync == $past(pin_in, 2))
    else $error("synchroniser delay wrong");

  // Unmapped address answers with error and zero data
  a_unmapped_err: assert property (
    access_ph |-> (pslverr == err_nxt) && (!err_nxt || prdata == '0))
    else $error("error flag or data wrong on unmapped address");

  // First mode register takes its two low bits
  a_mode1_write: assert property (
    acc_wr && idx_hit(paddr, `DIO_IDX_MODE1) |=> mode1_r == $past(pwdata[`DIO_MODE_W-1:0]))
    else $error("first mode register write wrong");

  // Second mode register takes its two low bits
  a_mode2_write: assert property (
    acc_wr && idx_hit(paddr, `DIO_IDX_MODE2) |=> mode2_r == $past(pwdata[`DIO_MODE_W-1:0]))
    else $error("second mode register write wrong");

  // Write with byte lane 0 off changes nothing
  a_strobe_masked: assert property (
    access_ph && pwrite && !pstrb[0]
      |=> $stable(pin_out) && $stable(pin_oe) && $stable(mode1_r) && $stable(mode2_r))
    else $error("masked write took effect");

  // Unused mode code ignores line writes
  a_off_mode_write: assert property (
    acc_wr && bank_hit(paddr, 0) && mode2_r == '0
      |=> $stable(pin_out) && $stable(pin_oe))
    else $error("write in unused mode took effect");

  // Write transfers return zero read data
  a_write_rdata: assert property (
    access_ph && pwrite |-> prdata == '0)
    else $error("write returned read data");

  // Error flag drops while deselected
  a_err_release: assert property (
    !psel |=> !pslverr)
    else $error("error flag held while idle");

  // Write to one bank leaves the others alone
  a_bank_isolated: assert property (
    acc_wr && bank_hit(paddr, 0)
      |=> $stable(pin_out[NL-1:LINE_W]) && $stable(pin_oe[NL-1:LINE_W]))
    else $error("write disturbed another bank");

  // Synchroniser starts from zero after reset
  a_sync_cleared: assert property (
    $past(rst) |-> pins_sync == '0)
    else $error("synchroniser not cleared by reset");

  // Main scenarios
  c_preset_write: cover property (acc_wr && bank_hit(paddr, 0) && mode2_r == `DIO_MODE_PRESET);
  c_dir_write:    cover property (acc_wr && bank_hit(paddr, 1) && mode2_r == `DIO_MODE_DIR);
  c_normal_read:  cover property (acc_rd && bank_hit(paddr, 2) && mode2_r == `DIO_MODE_NORMAL);
  c_unmapped:     cover property (access_ph && pslverr);
  c_mode_off:     cover property (acc_wr && bank_hit(paddr, 0) && mode2_r == '0);

endmodule : dio_port_top

// >>> tb/dio_field_model.sv
// Field wiring model that resolves each line from the port and the outside drive
`timescale 1ns/100ps
module dio_field_model (
  input  wire logic [23:0] pin_out,      // Level latch of the port
  input  wire logic [23:0] pin_oe,       // Port drives line when high
  input  wire logic [23:0] field_drive,  // Outside level on undriven lines
  output logic      [23:0] pin_in        // Resolved line level
);
  // Port wins where it drives, outside source elsewhere
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : field_drive[i];
    end
  end
endmodule : dio_field_model

// >>> tb/test_mode_switched_dio_port.sv
// Self-checking bench for the mode switched DIO port
`timescale 1ns/100ps
module test_mode_switched_dio_port;
  localparam logic [11:0] ADR_MODE1 = 12'h00C;  // First port mode register
  localparam logic [11:0] ADR_A     = 12'h010;  // Line register A
  localparam logic [11:0] ADR_B     = 12'h014;  // Line register B
  localparam logic [11:0] ADR_C     = 12'h018;  // Line register C
  localparam logic [11:0] ADR_MODE2 = 12'h01C;  // Line register mode
  localparam logic [11:0] ADR_NONE  = 12'h020;  // Unmapped word

  logic                clk;          // 200 MHz clock
  logic                rst;          // Synchronous reset
  logic                psel;         // APB select
  logic                penable;      // APB access phase
  logic                pwrite;       // APB direction
  logic [11:0]         paddr;        // APB byte address
  dio_port_pkg::word_t pwdata;       // APB write data
  logic [3:0]          pstrb;        // APB byte strobes
  dio_port_pkg::word_t prdata;       // APB read data
  logic                pready;       // APB ready
  logic                pslverr;      // APB error
  logic [23:0]         pin_in;       // Resolved line levels
  logic [23:0]         pin_out;      // Port level latch
  logic [23:0]         pin_oe;       // Port drive enables
  logic [23:0]         field_drive;  // Outside drive on lines
  dio_port_pkg::word_t rdat;         // Last read data
  logic                err;          // Last error flag
  int                  error_cnt;    // Mismatches
  int                  compares;     // Comparisons made
  int                  cycles;       // Timeout counter

  dio_port_top #(.ADDR_W(12), .LINE_W(8)) dio_port_top_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  dio_field_model dio_field_model_inst (
    .pin_out(pin_out), .pin_oe(pin_oe), .field_drive(field_drive), .pin_in(pin_in)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Summary, verdict and stop
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  // Word comparison
  task automatic chk_word(input dio_port_pkg::word_t got, input dio_port_pkg::word_t exp);
    compares = compares + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  // Flag comparison
  task automatic chk_bit(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer held until pready is seen
  task automatic xfer(input logic dir, input logic [11:0] a, input dio_port_pkg::word_t d,
                      output dio_port_pkg::word_t q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= dir;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Register write
  task automatic wr(input logic [11:0] a, input dio_port_pkg::word_t d);
    xfer(1'b1, a, d, rdat, err);
  endtask : wr

  // Register read with expected value
  task automatic rd(input logic [11:0] a, input dio_port_pkg::word_t exp);
    xfer(1'b0, a, 32'h00000000, rdat, err);
    chk_word(rdat, exp);
    chk_bit(err, 1'b0);
  endtask : rd

  // Main sequence
  initial begin
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    pstrb       = 4'hF;
    field_drive = 24'h000000;
    error_cnt   = 0;
    compares    = 0;
    cycles      = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values
    rd(ADR_MODE1, 32'h00000003);
    rd(ADR_MODE2, 32'h00000003);
    rd(ADR_A, 32'h00000000);
    rd(ADR_B, 32'h00000000);
    rd(ADR_C, 32'h00000000);
    // Preset mode, upper mode bits written as zero
    wr(ADR_MODE2, 32'h00000001);
    rd(ADR_MODE2, 32'h00000001);
    wr(ADR_A, 32'h000000A5);
    wr(ADR_B, 32'h0000005A);
    wr(ADR_C, 32'h000000C3);
    @(negedge clk);
    chk_word({8'h00, pin_out}, 32'h00C35AA5);
    chk_word({8'h00, pin_oe}, 32'h00000000);
    rd(ADR_A, 32'h000000A5);
    // Direction mode
    wr(ADR_MODE2, 32'h00000002);
    wr(ADR_A, 32'h0000000F);
    wr(ADR_B, 32'h000000F0);
    wr(ADR_C, 32'h00000081);
    @(negedge clk);
    chk_word({8'h00, pin_oe}, 32'h0081F00F);
    rd(ADR_B, 32'h000000F0);
    rd(ADR_A, 32'h0000000F);
    // Preset readback ignores direction
    wr(ADR_MODE2, 32'h00000001);
    rd(ADR_A, 32'h000000A5);
    rd(ADR_C, 32'h000000C3);
    // Normal mode with outside drive on input lines
    field_drive <= 24'h99663C;
    wr(ADR_MODE2, 32'h00000003);
    rd(ADR_A, 32'h00000035);
    rd(ADR_B, 32'h00000056);
    wr(ADR_A, 32'h000000FF);
    @(negedge clk);
    chk_word({8'h00, pin_out}, 32'h00C35AAF);
    rd(ADR_A, 32'h0000003F);
    // First mode register leaves line registers alone
    wr(ADR_MODE1, 32'h00000002);
    rd(ADR_MODE1, 32'h00000002);
    wr(ADR_A, 32'h00000000);
    @(negedge clk);
    chk_word({8'h00, pin_oe}, 32'h0081F00F);
    chk_word({8'h00, pin_out}, 32'h00C35AA0);
    // Unused mode code: line writes ignored, reads zero
    wr(ADR_MODE2, 32'h00000000);
    wr(ADR_A, 32'h00000055);
    rd(ADR_A, 32'h00000000);
    // Byte lane 0 strobe off: write ignored
    wr(ADR_MODE2, 32'h00000003);
    pstrb <= 4'h0;
    wr(ADR_A, 32'h000000FF);
    pstrb <= 4'hF;
    @(negedge clk);
    chk_word({8'h00, pin_out}, 32'h00C35AA0);
    // Unmapped word
    xfer(1'b0, ADR_NONE, 32'h00000000, rdat, err);
    chk_bit(err, 1'b1);
    chk_word(rdat, 32'h00000000);
    // Reset in mid run restores reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADR_MODE2, 32'h00000003);
    @(negedge clk);
    chk_word({8'h00, pin_out}, 32'h00000000);
    chk_word({8'h00, pin_oe}, 32'h00000000);
    end_sim();
  end
endmodule : test_mode_switched_dio_port
